// *** pdsr_pkg.sv ***
// Purpose: Constants for the pad drive strength register bank.
// Assumes: 16-bit register port addressed at the printed register offsets.
// Notes:   Masks mark implemented bits; every other bit is reserved.
package pdsr_pkg;
   localparam int          ADDR_W    = 16;
   localparam int          DATA_W    = 16;
   localparam int          NUM_REGS  = 5;
   // Register order used by every array below.
   localparam int          IDX_BCLK  = 0;
   localparam int          IDX_FCLK  = 1;
   localparam int          IDX_MULTI = 2;
   localparam int          IDX_SOUT  = 3;
   localparam int          IDX_MISC  = 4;
   localparam int          NUM_BCLK  = 12;
   localparam int          NUM_FCLK  = 12;
   localparam int          NUM_MULTI = 12;
   localparam int          NUM_SOUT  = 9;
   localparam int          NUM_MISC  = 7;
   localparam logic [15:0] ADDR_BIT_CLOCK_PAD_DRIVE      = 16'he247;
   localparam logic [15:0] ADDR_FRAME_CLOCK_PAD_DRIVE    = 16'he248;
   localparam logic [15:0] ADDR_MULTIPURPOSE_PAD_DRIVE   = 16'he249;
   localparam logic [15:0] ADDR_SERIAL_OUT_PAD_DRIVE     = 16'he24a;
   localparam logic [15:0] ADDR_MISC_PAD_DRIVE           = 16'he24c;
   localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
      ADDR_BIT_CLOCK_PAD_DRIVE, ADDR_FRAME_CLOCK_PAD_DRIVE, ADDR_MULTIPURPOSE_PAD_DRIVE,
      ADDR_SERIAL_OUT_PAD_DRIVE, ADDR_MISC_PAD_DRIVE};
   localparam logic [15:0] MASK_BIT_CLOCK    = 16'h0fff;
   localparam logic [15:0] MASK_FRAME_CLOCK  = 16'h0fff;
   localparam logic [15:0] MASK_MULTIPURPOSE = 16'h0fff;
   localparam logic [15:0] MASK_SERIAL_OUT   = 16'h01ff;
   localparam logic [15:0] MASK_MISC         = 16'h007f;
   localparam logic [15:0] REG_MASK [NUM_REGS] = '{
      MASK_BIT_CLOCK, MASK_FRAME_CLOCK, MASK_MULTIPURPOSE, MASK_SERIAL_OUT, MASK_MISC};
   // All strength bits come up as low drive.
   localparam logic [15:0] RESET_VALUE = 16'h0000;
   // Bit positions inside the misc register.
   localparam int          MISC_MCLK_BIT   = 0;
   localparam int          MISC_SPDIF_BIT  = 1;
   localparam int          MISC_CPDOUT_BIT = 2;
   localparam int          MISC_AD0_BIT    = 3;
   localparam int          MISC_AD1_BIT    = 4;
   localparam int          MISC_LATCH_BIT  = 5;
   localparam int          MISC_CPCLK_BIT  = 6;
endpackage

// *** pdsr_reg_if.sv ***
// Purpose: Write path and stored value of one strength register.
// Assumes: Single clock domain shared by both ends.
// Notes:   The bank decoder drives the strobe; the register returns its value.
`timescale 1ns/1ps
interface pdsr_reg_if;
   logic        wrEn;
   logic [15:0] wrData;
   logic [15:0] value;
   modport ctrl  (output wrEn, output wrData, input value);
   modport owner (input wrEn, input wrData, output value);
endinterface

// *** pdsr_drive_reg.sv ***
// Purpose: One 16-bit strength register with reserved bits held at zero.
// Assumes: Reset is already synchronised to the clock.
// Notes:   MASK marks the implemented bits.
`timescale 1ns/1ps
module pdsr_drive_reg #(
   parameter logic [15:0] MASK = 16'hffff
) (
   input  wire logic  clock,
   input  wire logic  rstSync_n,
   pdsr_reg_if.owner  bus
);
   import pdsr_pkg::*;

   logic [15:0] value_q;
   logic [15:0] value_d;

   assign value_d   = bus.wrEn ? (bus.wrData & MASK) : value_q; // R8
   assign bus.value = value_q;

   always_ff @(posedge clock or negedge rstSync_n) begin
      if (!rstSync_n) begin
         value_q <= RESET_VALUE; // R7
      end else begin
         value_q <= value_d;
      end
   end
endmodule

// *** pdsr_pad_drive_bank.sv ***
// Purpose: Pad drive strength register bank feeding the pad cells.
// Assumes: Register port strobes are one cycle long and synchronous to clock.
// Notes:   A high output selects the strong pad driver; low selects the weak one.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Behaviour
// (R1) Bit-clock register bits 11..0 set bit clock pad drive while pin is master.
// (R2) A cleared bit selects low drive, a set bit selects high drive.
// (R3) Frame-clock register bits 11..0 set frame clock pad drive while pin is master.
// (R4) Multipurpose register bits 11..0 set pad drive while pin is an output.
// (R5) Serial-output register bits 8..0 set serial data output pads 8..0.
// (R6) Misc register bits 6..0 drive control port, S/PDIF and clock output pads.
// (R7) Every strength bit resets to low drive; software keeps it unless needed.
// (R8) Reserved bits read as zero and ignore writes.
module pdsr_pad_drive_bank (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            rst_n,
   // Register port
   input  wire logic [pdsr_pkg::ADDR_W-1:0]     regAddr,
   input  wire logic [pdsr_pkg::DATA_W-1:0]     regWrData,
   input  wire logic                            regWrite,
   input  wire logic                            regRead,
   output logic      [pdsr_pkg::DATA_W-1:0]     regRdData,
   // Pin direction state from the pin controllers
   input  wire logic [pdsr_pkg::NUM_BCLK-1:0]   bitClockIsMaster,
   input  wire logic [pdsr_pkg::NUM_FCLK-1:0]   frameClockIsMaster,
   input  wire logic [pdsr_pkg::NUM_MULTI-1:0]  multipurposePinIsOutput,
   // High drive selects to the pad cells
   output logic      [pdsr_pkg::NUM_BCLK-1:0]   bitClockHighDrive,
   output logic      [pdsr_pkg::NUM_FCLK-1:0]   frameClockHighDrive,
   output logic      [pdsr_pkg::NUM_MULTI-1:0]  multipurposePinHighDrive,
   output logic      [pdsr_pkg::NUM_SOUT-1:0]   serialDataOutputPinHighDrive,
   output logic                                 controlPortClockPinHighDrive,
   output logic                                 controlPortLatchPinHighDrive,
   output logic                                 address1OrDataInPinHighDrive,
   output logic                                 address0PinHighDrive,
   output logic                                 controlPortDataOutPinHighDrive,
   output logic                                 spdifOutputPinHighDrive,
   output logic                                 masterClockOutputPinHighDrive
);
   import pdsr_pkg::*;

   // Reset is released through two flops so the bank never leaves reset mid-edge.
   logic        rstMetaN_q;
   logic        rstSyncN_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMetaN_q <= 1'b0;
         rstSyncN_q <= 1'b0;
      end else begin
         rstMetaN_q <= 1'b1;
         rstSyncN_q <= rstMetaN_q;
      end
   end

   pdsr_reg_if  regBus [NUM_REGS] ();
   logic [NUM_REGS-1:0] addrHit;
   logic [15:0]         regValue [NUM_REGS];
   logic [15:0]         readMux;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : gen_reg
         assign addrHit[g]         = (regAddr == REG_ADDR[g]);
         assign regBus[g].wrEn     = regWrite && addrHit[g];
         assign regBus[g].wrData   = regWrData;
         assign regValue[g]        = regBus[g].value;
         pdsr_drive_reg #(
            .MASK      (REG_MASK[g])
         ) u_reg (
            .clock     (clock),
            .rstSync_n (rstSyncN_q),
            .bus       (regBus[g])
         );
      end
   endgenerate

   // Unmapped addresses read as zero; stored values already hold reserved bits at zero.
   always_comb begin
      readMux = 16'h0000;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (addrHit[i]) begin
            readMux = regValue[i]; // R8
         end
      end
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clock or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         regRdData <= 16'h0000;
      end else begin
         regRdData <= regRead ? readMux : 16'h0000;
      end
   end

   // Clock and multipurpose settings only reach a pad the device is driving.
   logic [NUM_BCLK-1:0]  bclkDrive;
   logic [NUM_FCLK-1:0]  fclkDrive;
   logic [NUM_MULTI-1:0] multiDrive;
   logic [NUM_MISC-1:0]  miscDrive;

   assign bclkDrive = regValue[IDX_BCLK][NUM_BCLK-1:0] & bitClockIsMaster; // R1 R2
   assign fclkDrive = regValue[IDX_FCLK][NUM_FCLK-1:0] & frameClockIsMaster; // R3 R2
   assign multiDrive = regValue[IDX_MULTI][NUM_MULTI-1:0] & multipurposePinIsOutput; // R4 R2
   assign miscDrive = regValue[IDX_MISC][NUM_MISC-1:0];

   always_ff @(posedge clock or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         bitClockHighDrive              <= '0; // R7
         frameClockHighDrive            <= '0;
         multipurposePinHighDrive       <= '0;
         serialDataOutputPinHighDrive   <= '0;
         controlPortClockPinHighDrive   <= 1'b0;
         controlPortLatchPinHighDrive   <= 1'b0;
         address1OrDataInPinHighDrive   <= 1'b0;
         address0PinHighDrive           <= 1'b0;
         controlPortDataOutPinHighDrive <= 1'b0;
         spdifOutputPinHighDrive        <= 1'b0;
         masterClockOutputPinHighDrive  <= 1'b0;
      end else begin
         bitClockHighDrive              <= bclkDrive;
         frameClockHighDrive            <= fclkDrive;
         multipurposePinHighDrive       <= multiDrive;
         serialDataOutputPinHighDrive   <= regValue[IDX_SOUT][NUM_SOUT-1:0]; // R5
         controlPortClockPinHighDrive   <= miscDrive[MISC_CPCLK_BIT]; // R6
         controlPortLatchPinHighDrive   <= miscDrive[MISC_LATCH_BIT];
         address1OrDataInPinHighDrive   <= miscDrive[MISC_AD1_BIT];
         address0PinHighDrive           <= miscDrive[MISC_AD0_BIT];
         controlPortDataOutPinHighDrive <= miscDrive[MISC_CPDOUT_BIT];
         spdifOutputPinHighDrive        <= miscDrive[MISC_SPDIF_BIT];
         masterClockOutputPinHighDrive  <= miscDrive[MISC_MCLK_BIT];
      end
   end
endmodule

// *** pdsr_bank_monitor.sv ***
// Purpose: Port-level checks for the pad drive strength bank.
// Assumes: Register strobes are one cycle long; reset releases cleanly.
// Notes:   Pad outputs lag a write by two edges, direction inputs by one.
`timescale 1ns/1ps
module pdsr_bank_monitor (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // Register port
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [15:0] regRdData,
   // Direction state
   input wire logic [11:0] bitClockIsMaster,
   input wire logic [11:0] frameClockIsMaster,
   input wire logic [11:0] multipurposePinIsOutput,
   // Pad drive selects
   input wire logic [11:0] bitClockHighDrive,
   input wire logic [11:0] frameClockHighDrive,
   input wire logic [11:0] multipurposePinHighDrive,
   input wire logic [8:0]  serialDataOutputPinHighDrive,
   input wire logic        controlPortClockPinHighDrive,
   input wire logic        masterClockOutputPinHighDrive
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   rd_idle_a: assert property (!$past(regRead) |-> regRdData == 16'h0)
      else $error("read data not zero outside a read");
   rd_unmapped_a: assert property ($past(regRead) && $past(regAddr) == 16'he24b |-> regRdData == 16'h0)
      else $error("unmapped read not zero");
   misc_res_a: assert property ($past(regRead) && $past(regAddr) == 16'he24c |-> regRdData[15:7] == 9'h0)
      else $error("misc reserved bits read nonzero");
   sout_res_a: assert property ($past(regRead) && $past(regAddr) == 16'he24a |-> regRdData[15:9] == 7'h0)
      else $error("serial reserved bits read nonzero");
   bclk_gate_a: assert property ((bitClockHighDrive & ~$past(bitClockIsMaster)) == 12'h0)
      else $error("bit clock high drive while not master");
   fclk_gate_a: assert property ((frameClockHighDrive & ~$past(frameClockIsMaster)) == 12'h0)
      else $error("frame clock high drive while not master");
   mp_gate_a: assert property ((multipurposePinHighDrive & ~$past(multipurposePinIsOutput)) == 12'h0)
      else $error("multipurpose high drive while not output");
   sout_write_a: assert property (regWrite && regAddr == 16'he24a |-> ##2 serialDataOutputPinHighDrive == $past(regWrData[8:0], 2))
      else $error("serial output drive does not follow write");
   misc_write_a: assert property (regWrite && regAddr == 16'he24c |-> ##2
      {controlPortClockPinHighDrive, masterClockOutputPinHighDrive} == {$past(regWrData[6], 2), $past(regWrData[0], 2)})
      else $error("misc drive does not follow write");
endmodule

bind pdsr_pad_drive_bank pdsr_bank_monitor pdsr_bank_monitor_inst (
   .clock                         (clock),
   .rst_n                         (rst_n),
   .regAddr                       (regAddr),
   .regWrData                     (regWrData),
   .regWrite                      (regWrite),
   .regRead                       (regRead),
   .regRdData                     (regRdData),
   .bitClockIsMaster              (bitClockIsMaster),
   .frameClockIsMaster            (frameClockIsMaster),
   .multipurposePinIsOutput       (multipurposePinIsOutput),
   .bitClockHighDrive             (bitClockHighDrive),
   .frameClockHighDrive           (frameClockHighDrive),
   .multipurposePinHighDrive      (multipurposePinHighDrive),
   .serialDataOutputPinHighDrive  (serialDataOutputPinHighDrive),
   .controlPortClockPinHighDrive  (controlPortClockPinHighDrive),
   .masterClockOutputPinHighDrive (masterClockOutputPinHighDrive)
);

// *** testbench.sv ***
// Purpose: Self-checking bench for the pad drive strength bank.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes:   Direction inputs start high so register bits reach the pads.
`timescale 1ns/1ps
module testbench;
   import pdsr_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [15:0] regAddr = 16'h0, regWrData = 16'h0, regRdData;
   logic [11:0] bitClockIsMaster = 12'hfff, frameClockIsMaster = 12'hfff;
   logic [11:0] multipurposePinIsOutput = 12'hfff;
   logic [11:0] bitClockHighDrive, frameClockHighDrive, multipurposePinHighDrive;
   logic [8:0]  serialDataOutputPinHighDrive;
   logic controlPortClockPinHighDrive, controlPortLatchPinHighDrive, address1OrDataInPinHighDrive;
   logic address0PinHighDrive, controlPortDataOutPinHighDrive, spdifOutputPinHighDrive;
   logic masterClockOutputPinHighDrive;
   logic [15:0] padOut [NUM_REGS];
   int failCount = 0, checkCount = 0, cycles = 0;
   pdsr_pad_drive_bank pdsr_pad_drive_bank_inst (
      .clock                          (clock),
      .rst_n                          (rst_n),
      .regAddr                        (regAddr),
      .regWrData                      (regWrData),
      .regWrite                       (regWrite),
      .regRead                        (regRead),
      .regRdData                      (regRdData),
      .bitClockIsMaster               (bitClockIsMaster),
      .frameClockIsMaster             (frameClockIsMaster),
      .multipurposePinIsOutput        (multipurposePinIsOutput),
      .bitClockHighDrive              (bitClockHighDrive),
      .frameClockHighDrive            (frameClockHighDrive),
      .multipurposePinHighDrive       (multipurposePinHighDrive),
      .serialDataOutputPinHighDrive   (serialDataOutputPinHighDrive),
      .controlPortClockPinHighDrive   (controlPortClockPinHighDrive),
      .controlPortLatchPinHighDrive   (controlPortLatchPinHighDrive),
      .address1OrDataInPinHighDrive   (address1OrDataInPinHighDrive),
      .address0PinHighDrive           (address0PinHighDrive),
      .controlPortDataOutPinHighDrive (controlPortDataOutPinHighDrive),
      .spdifOutputPinHighDrive        (spdifOutputPinHighDrive),
      .masterClockOutputPinHighDrive  (masterClockOutputPinHighDrive)
   );
   always #5 clock = ~clock;
   always_comb padOut = '{16'(bitClockHighDrive), 16'(frameClockHighDrive),
      16'(multipurposePinHighDrive), 16'(serialDataOutputPinHighDrive),
      16'({controlPortClockPinHighDrive, controlPortLatchPinHighDrive, address1OrDataInPinHighDrive,
      address0PinHighDrive, controlPortDataOutPinHighDrive, spdifOutputPinHighDrive,
      masterClockOutputPinHighDrive})};
   task automatic finalReport();
      if (failCount == 0 && checkCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failCount++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      regWrite <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clock);
      regRead <= 1'b1; regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   // Every register and pad select must come up as low drive.
   task automatic resetScan();
      for (int i = 0; i < NUM_REGS; i++) begin
         rd(REG_ADDR[i], RESET_VALUE);
         chk(padOut[i], 16'h0);
      end
   endtask
   // All ones written; only implemented bits may stick and reach the pads.
   task automatic maskScan();
      for (int i = 0; i < NUM_REGS; i++) begin
         wr(REG_ADDR[i], 16'hffff);
         rd(REG_ADDR[i], REG_MASK[i]);
         chk(padOut[i], REG_MASK[i]);
      end
      wr(16'he24b, 16'hffff);
      rd(16'he24b, 16'h0);
   endtask
   // Drive select follows the pin direction one edge later.
   task automatic gating();
      @(posedge clock);
      bitClockIsMaster <= 12'ha5a; frameClockIsMaster <= 12'h3c3; multipurposePinIsOutput <= 12'h000;
      repeat (2) @(posedge clock);
      #1 chk(padOut[IDX_BCLK], 16'h0a5a);
      chk(padOut[IDX_FCLK], 16'h03c3);
      chk(padOut[IDX_MULTI], 16'h0);
      wr(ADDR_SERIAL_OUT_PAD_DRIVE, 16'hfe00);
      @(posedge clock);
      #1 chk(padOut[IDX_SOUT], 16'h0);
   endtask
   // A write followed at once by a read must return the new value.
   task automatic backToBack();
      @(posedge clock);
      regWrite <= 1'b1; regAddr <= ADDR_BIT_CLOCK_PAD_DRIVE; regWrData <= 16'h1234;
      @(posedge clock);
      regWrite <= 1'b0; regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk(regRdData, 16'h0234);
      chk(padOut[IDX_BCLK], 16'h0210);
   endtask
   // A reset in mid-run must bring every register and pad back to low drive.
   task automatic midReset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      resetScan();
   endtask
   // One bit at a time proves the order of the misc pads.
   task automatic miscWalk();
      for (int i = 0; i < NUM_MISC; i++) begin
         wr(ADDR_MISC_PAD_DRIVE, 16'hff80 | (16'h1 << i));
         @(posedge clock);
         #1 chk(padOut[IDX_MISC], 16'h1 << i);
      end
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         failCount++;
         finalReport();
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      resetScan();
      maskScan();
      gating();
      backToBack();
      miscWalk();
      midReset();
      finalReport();
   end
endmodule
